// ==== logic/lmts_params.svh ====
`ifndef LMTS_PARAMS_SVH
`define LMTS_PARAMS_SVH

// ****************************************
// register indexes (byte address = 4 * index)
// ****************************************
`define LMTS_IDX_TCON      8'h88
`define LMTS_IDX_TMOD      8'h89
`define LMTS_IDX_T0_LOW    8'h8a
`define LMTS_IDX_T1_LOW    8'h8b
`define LMTS_IDX_T0_HIGH   8'h8c
`define LMTS_IDX_T1_HIGH   8'h8d
`define LMTS_IDX_TIMER_RATE_AND_MOVE_STRETCH     8'h8e
`define LMTS_IDX_TIMER2_CONTROL     8'hc8
`define LMTS_IDX_RCAP_LOW  8'hca
`define LMTS_IDX_RCAP_HIGH 8'hcb
`define LMTS_IDX_T2_LOW    8'hcc
`define LMTS_IDX_T2_HIGH   8'hcd
`define LMTS_IDX_AUX       8'hd8

// ****************************************
// field positions
// ****************************************
`define LMTS_TCON_TF1      7
`define LMTS_TCON_TR1      6
`define LMTS_TCON_TF0      5
`define LMTS_TCON_TR0      4
`define LMTS_TMOD_GATE1    7
`define LMTS_TMOD_CT1      6
`define LMTS_TMOD_M1_HI    5
`define LMTS_TMOD_M1_LO    4
`define LMTS_TMOD_GATE0    3
`define LMTS_TMOD_CT0      2
`define LMTS_TMOD_M0_HI    1
`define LMTS_TMOD_M0_LO    0
`define LMTS_CK_T2M        5
`define LMTS_CK_T1M        4
`define LMTS_CK_T0M        3
`define LMTS_CK_MD_HI      2
`define LMTS_CK_MD_LO      0
`define LMTS_T2_TF2        7
`define LMTS_T2_T2_EXTERNAL_FLAG       6
`define LMTS_T2_RCLK       5
`define LMTS_T2_SERIAL_TX_CLOCK_SEL       4
`define LMTS_T2_T2_TRIGGER_ENABLE      3
`define LMTS_T2_TR2        2
`define LMTS_T2_CT2        1
`define LMTS_T2_CPRL2      0
`define LMTS_AUX_T2IE      0

// ****************************************
// reset values
// ****************************************
`define LMTS_TIMER_RATE_AND_MOVE_STRETCH_RST     6'h01
`define LMTS_BYTE_RST      8'h00
`define LMTS_MOVE_BASE     4'h2

// ****************************************
// timing: cpu clocks per increment
// ****************************************
`define LMTS_DIV_BAUD      2
`define LMTS_DIV_FAST      4
`define LMTS_DIV_SLOW      12

`endif

// ==== logic/lmts_pkg.sv ====
package lmts_pkg;

  typedef enum logic [1:0] {
    LMTS_MODE_13BIT  = 2'b00,
    LMTS_MODE_16BIT  = 2'b01,
    LMTS_MODE_RELOAD = 2'b10,
    LMTS_MODE_SPLIT  = 2'b11
  } lmts_mode_t;

endpackage

// ==== logic/lmts_prescale.sv ====
`timescale 1ns/10ps
`include "lmts_params.svh"

module lmts_prescale (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tick_baud,
  output logic      tick_fast,
  output logic      tick_slow
);

  localparam logic [3:0] LAST = 4'(`LMTS_DIV_SLOW - 1);

  logic [3:0] cnt_r;

  // one free-running counter serves all three rates so they stay phase aligned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= (cnt_r == LAST) ? 4'h0 : cnt_r + 4'h1;
    end
  end

  assign tick_baud = (cnt_r % 4'(`LMTS_DIV_BAUD)) == 4'(`LMTS_DIV_BAUD - 1);
  assign tick_fast = (cnt_r % 4'(`LMTS_DIV_FAST)) == 4'(`LMTS_DIV_FAST - 1);
  assign tick_slow = cnt_r == LAST;

endmodule

// ==== logic/lmts_pin_sync.sv ====
`timescale 1ns/10ps

module lmts_pin_sync #(
  parameter int W = 6
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_level,
  output logic      [W-1:0] pin_fall
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;

  // reset high: idle pins read as deasserted, no false edge at release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '1;
      sync_r <= '1;
      prev_r <= '1;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign pin_level = sync_r;
  assign pin_fall  = prev_r & ~sync_r;

endmodule

// ==== logic/lmts_timer_set.sv ====
// Our own choice: register access over APB.
`timescale 1ns/10ps
`include "lmts_params.svh"


module lmts_timer_set import lmts_pkg::*; #(
  parameter int ADDR_W = 12
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              t0_event_pin,
  input  wire logic              t1_event_pin,
  input  wire logic              t2_event_pin,
  input  wire logic              t2_trigger_pin,
  input  wire logic              ext_irq0_pin,
  input  wire logic              ext_irq1_pin,
  input  wire logic              t0_vector_ack,
  input  wire logic              t1_vector_ack,
  output logic                   t0_overflow_pulse,
  output logic                   t1_overflow_pulse,
  output logic                   t0_irq_req,
  output logic                   t1_irq_req,
  output logic                   t2_irq_req,
  output logic                   serial_rx_clock,
  output logic                   serial_tx_clock,
  output logic      [3:0]        move_cycles
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    reg_hit = a == ADDR_W'({idx, 2'b00});
  endfunction

  // returns {overflow, high, low} after one step of a timer 0/1 counter
  function automatic logic [16:0] t01_step(input lmts_mode_t mode, input logic [7:0] hi,
                                           input logic [7:0] lo, input logic inc);
    logic [13:0] c13;
    logic [16:0] c16;
    logic [8:0]  c8;
    c13 = {1'b0, hi, lo[4:0]} + 14'h1;
    c16 = {1'b0, hi, lo} + 17'h1;
    c8  = {1'b0, lo} + 9'h1;
    t01_step = {1'b0, hi, lo};
    if (inc) begin
      unique case (mode)
        LMTS_MODE_13BIT:  t01_step = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
        LMTS_MODE_16BIT:  t01_step = c16;
        LMTS_MODE_RELOAD: t01_step = {c8[8], hi, (c8[8] ? hi : c8[7:0])};
        LMTS_MODE_SPLIT:  t01_step = {c8[8], hi, c8[7:0]};
      endcase
    end
  endfunction

  // ****************************************
  // pins and prescaler
  // ****************************************
  logic [5:0] pin_level;
  logic [5:0] pin_fall;
  logic       tick_baud;
  logic       tick_fast;
  logic       tick_slow;

  lmts_pin_sync #(
    .W (6)
  ) u_sync (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_in    ({ext_irq1_pin, ext_irq0_pin, t2_trigger_pin, t2_event_pin,
                 t1_event_pin, t0_event_pin}),
    .pin_level (pin_level),
    .pin_fall  (pin_fall)
  );

  lmts_prescale u_pre (
    .pclk      (pclk),
    .presetn   (presetn),
    .tick_baud (tick_baud),
    .tick_fast (tick_fast),
    .tick_slow (tick_slow)
  );

  wire t0_fall   = pin_fall[0];
  wire t1_fall   = pin_fall[1];
  wire t2_fall   = pin_fall[2];
  wire trig_fall = pin_fall[3];
  wire irq0_high = pin_level[4];
  wire irq1_high = pin_level[5];

  // ****************************************
  // register state
  // ****************************************
  logic [7:0]  tmod_r;
  logic        t0_run_r;
  logic        t1_run_r;
  logic        t0_overflow_flag_r;
  logic        t1_overflow_flag_r;
  logic [7:0]  t0_count_low_r;
  logic [7:0]  t0_count_high_r;
  logic [7:0]  t1_count_low_r;
  logic [7:0]  t1_count_high_r;
  logic [5:0]  timer_rate_and_move_stretch_r;
  logic        t2_overflow_flag_r;
  logic        t2_external_flag_r;
  logic [5:0]  t2_ctl_r;
  logic [15:0] t2_reload_r;
  logic [15:0] t2_count_r;
  logic        t2_irq_enable_r;
  logic        t0_pulse_r;
  logic        t1_pulse_r;
  logic        t2_baud_pulse_r;
  logic [31:0] prdata_r;

  // ****************************************
  // apb decode
  // ****************************************
  wire h_tcon  = reg_hit(paddr, `LMTS_IDX_TCON);
  wire h_tmod  = reg_hit(paddr, `LMTS_IDX_TMOD);
  wire h_tl0   = reg_hit(paddr, `LMTS_IDX_T0_LOW);
  wire h_tl1   = reg_hit(paddr, `LMTS_IDX_T1_LOW);
  wire h_th0   = reg_hit(paddr, `LMTS_IDX_T0_HIGH);
  wire h_th1   = reg_hit(paddr, `LMTS_IDX_T1_HIGH);
  wire h_ck    = reg_hit(paddr, `LMTS_IDX_TIMER_RATE_AND_MOVE_STRETCH);
  wire h_timer2_control = reg_hit(paddr, `LMTS_IDX_TIMER2_CONTROL);
  wire h_rcl   = reg_hit(paddr, `LMTS_IDX_RCAP_LOW);
  wire h_rch   = reg_hit(paddr, `LMTS_IDX_RCAP_HIGH);
  wire h_tl2   = reg_hit(paddr, `LMTS_IDX_T2_LOW);
  wire h_th2   = reg_hit(paddr, `LMTS_IDX_T2_HIGH);
  wire h_aux   = reg_hit(paddr, `LMTS_IDX_AUX);
  wire addr_ok = h_tcon | h_tmod | h_tl0 | h_tl1 | h_th0 | h_th1 | h_ck | h_timer2_control |
                 h_rcl | h_rch | h_tl2 | h_th2 | h_aux;

  wire        access = psel & penable;
  wire        wr     = access & pwrite & pstrb[0] & addr_ok;
  wire [7:0]  wbyte  = pwdata[7:0];

  assign pready  = 1'b1;
  assign pslverr = access & ~addr_ok;
  assign prdata  = prdata_r;

  wire [7:0] tcon_rd = {t1_overflow_flag_r, t1_run_r, t0_overflow_flag_r, t0_run_r, 4'h0};
  wire [7:0] timer2_control_rd = {t2_overflow_flag_r, t2_external_flag_r, t2_ctl_r};
  wire [7:0] rd_byte =
      h_tcon  ? tcon_rd :
      h_tmod  ? tmod_r :
      h_tl0   ? t0_count_low_r :
      h_tl1   ? t1_count_low_r :
      h_th0   ? t0_count_high_r :
      h_th1   ? t1_count_high_r :
      h_ck    ? {2'b00, timer_rate_and_move_stretch_r} :
      h_timer2_control ? timer2_control_rd :
      h_rcl   ? t2_reload_r[7:0] :
      h_rch   ? t2_reload_r[15:8] :
      h_tl2   ? t2_count_r[7:0] :
      h_th2   ? t2_count_r[15:8] :
      h_aux   ? {7'h00, t2_irq_enable_r} : 8'h00;

  // ****************************************
  // timers 0 and 1
  // ****************************************
  // two-bit mode field
  wire lmts_mode_t t0_mode = lmts_mode_t'(tmod_r[`LMTS_TMOD_M0_HI:`LMTS_TMOD_M0_LO]);
  wire lmts_mode_t t1_mode = lmts_mode_t'(tmod_r[`LMTS_TMOD_M1_HI:`LMTS_TMOD_M1_LO]);
  wire t0_split = t0_mode == LMTS_MODE_SPLIT;

  wire t0_prescaled = timer_rate_and_move_stretch_r[`LMTS_CK_T0M] ? tick_fast : tick_slow;
  wire t1_prescaled = timer_rate_and_move_stretch_r[`LMTS_CK_T1M] ? tick_fast : tick_slow;
  wire t0_src = tmod_r[`LMTS_TMOD_CT0] ? t0_fall : t0_prescaled;
  wire t1_src = tmod_r[`LMTS_TMOD_CT1] ? t1_fall : t1_prescaled;

  wire t0_inc = t0_run_r & (~tmod_r[`LMTS_TMOD_GATE0] | irq0_high) & t0_src;
  // timer 1 switched by its mode when timer 0 is split
  // timer 1 holds in mode 3
  wire t1_inc = (t0_split | t1_run_r) & (~tmod_r[`LMTS_TMOD_GATE1] | irq1_high) & t1_src &
                (t1_mode != LMTS_MODE_SPLIT);
  // split high byte runs on timer 1 run bit, prescaled only
  wire th0_inc = t0_split & t1_run_r & t0_prescaled;

  wire [16:0] t0_step = t01_step(t0_mode, t0_count_high_r, t0_count_low_r, t0_inc);
  wire [16:0] t1_step = t01_step(t1_mode, t1_count_high_r, t1_count_low_r, t1_inc);
  wire [8:0]  th0_sum = {1'b0, t0_count_high_r} + 9'(th0_inc);

  wire t0_ovf  = t0_step[16];
  wire t1_ovf  = t1_step[16];
  // split high byte owns timer 1 flag
  wire tf1_set = t0_split ? th0_sum[8] : t1_ovf;

  wire [7:0] th0_nxt = t0_split ? th0_sum[7:0] : t0_step[15:8];

  // overflow sets flag; write loses to set
  wire tcon_wr = wr & h_tcon;
  wire tf0_nxt = t0_ovf | (~t0_vector_ack &
                 (tcon_wr ? wbyte[`LMTS_TCON_TF0] : t0_overflow_flag_r));
  wire tf1_nxt = tf1_set | (~t1_vector_ack &
                 (tcon_wr ? wbyte[`LMTS_TCON_TF1] : t1_overflow_flag_r));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmod_r             <= `LMTS_BYTE_RST;
      t0_run_r           <= 1'b0;
      t1_run_r           <= 1'b0;
      t0_overflow_flag_r <= 1'b0;
      t1_overflow_flag_r <= 1'b0;
      t0_count_low_r     <= `LMTS_BYTE_RST;
      t0_count_high_r    <= `LMTS_BYTE_RST;
      t1_count_low_r     <= `LMTS_BYTE_RST;
      t1_count_high_r    <= `LMTS_BYTE_RST;
      t0_pulse_r         <= 1'b0;
      t1_pulse_r         <= 1'b0;
    end else begin
      if (wr && h_tmod) begin
        tmod_r <= wbyte;
      end
      if (tcon_wr) begin
        t0_run_r <= wbyte[`LMTS_TCON_TR0];
        t1_run_r <= wbyte[`LMTS_TCON_TR1];
      end
      t0_overflow_flag_r <= tf0_nxt;
      t1_overflow_flag_r <= tf1_nxt;
      // a software write of a count byte takes priority over the increment
      t0_count_low_r  <= (wr && h_tl0) ? wbyte : t0_step[7:0];
      t0_count_high_r <= (wr && h_th0) ? wbyte : th0_nxt;
      t1_count_low_r  <= (wr && h_tl1) ? wbyte : t1_step[7:0];
      t1_count_high_r <= (wr && h_th1) ? wbyte : t1_step[15:8];
      t0_pulse_r <= t0_ovf;
      t1_pulse_r <= t1_ovf;
    end
  end

  assign t0_overflow_pulse = t0_pulse_r;
  assign t1_overflow_pulse = t1_pulse_r;
  assign t0_irq_req        = t0_overflow_flag_r;
  assign t1_irq_req        = t1_overflow_flag_r;

  // ****************************************
  // rate and move-stretch control
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // rate bits reset to twelve clocks
      timer_rate_and_move_stretch_r <= `LMTS_TIMER_RATE_AND_MOVE_STRETCH_RST;
    end else if (wr && h_ck) begin
      timer_rate_and_move_stretch_r <= wbyte[5:0];
    end
  end

  assign move_cycles = `LMTS_MOVE_BASE + {1'b0, timer_rate_and_move_stretch_r[`LMTS_CK_MD_HI:`LMTS_CK_MD_LO]};

  // ****************************************
  // timer 2
  // ****************************************
  wire rx_sel  = t2_ctl_r[`LMTS_T2_RCLK];
  wire tx_sel  = t2_ctl_r[`LMTS_T2_SERIAL_TX_CLOCK_SEL];
  wire baud    = rx_sel | tx_sel;
  wire trig_en = t2_ctl_r[`LMTS_T2_T2_TRIGGER_ENABLE];
  wire cap_sel = t2_ctl_r[`LMTS_T2_CPRL2];

  wire t2_internal = baud ? tick_baud : (timer_rate_and_move_stretch_r[`LMTS_CK_T2M] ? tick_fast : tick_slow);
  wire t2_inc = t2_ctl_r[`LMTS_T2_TR2] & (t2_ctl_r[`LMTS_T2_CT2] ? t2_fall : t2_internal);

  wire [16:0] t2_sum = {1'b0, t2_count_r} + 17'(t2_inc);
  wire        t2_ovf = t2_sum[16];

  wire trig_evt = trig_fall & trig_en;
  wire capture = trig_evt & cap_sel & ~baud;
  wire reload  = (~cap_sel | baud) & (t2_ovf | (trig_evt & ~baud));

  // reload from or capture into reload pair
  wire [15:0] t2_count_nxt = reload ? t2_reload_r : t2_sum[15:0];

  // written one stays set and requests
  wire timer2_control_wr = wr & h_timer2_control;
  wire tf2_nxt  = (t2_ovf & ~baud) |
                  (timer2_control_wr ? wbyte[`LMTS_T2_TF2] : t2_overflow_flag_r);
  wire t2_external_flag_nxt = trig_evt | (timer2_control_wr ? wbyte[`LMTS_T2_T2_EXTERNAL_FLAG] : t2_external_flag_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t2_ctl_r           <= 6'h00;
      t2_overflow_flag_r <= 1'b0;
      t2_external_flag_r <= 1'b0;
      t2_reload_r        <= 16'h0000;
      t2_count_r         <= 16'h0000;
      t2_irq_enable_r    <= 1'b0;
      t2_baud_pulse_r    <= 1'b0;
    end else begin
      if (timer2_control_wr) begin
        t2_ctl_r <= wbyte[5:0];
      end
      if (wr && h_aux) begin
        t2_irq_enable_r <= wbyte[`LMTS_AUX_T2IE];
      end
      t2_overflow_flag_r <= tf2_nxt;
      t2_external_flag_r <= t2_external_flag_nxt;
      // a capture edge wins over a software write of the same byte
      if (capture) begin
        t2_reload_r <= t2_count_r;
      end else begin
        if (wr && h_rcl) begin
          t2_reload_r[7:0] <= wbyte;
        end
        if (wr && h_rch) begin
          t2_reload_r[15:8] <= wbyte;
        end
      end
      t2_count_r[7:0]  <= (wr && h_tl2) ? wbyte : t2_count_nxt[7:0];
      t2_count_r[15:8] <= (wr && h_th2) ? wbyte : t2_count_nxt[15:8];
      t2_baud_pulse_r <= t2_ovf & baud;
    end
  end

  assign t2_irq_req = (t2_overflow_flag_r | t2_external_flag_r) & t2_irq_enable_r;

  assign serial_rx_clock = rx_sel ? t2_baud_pulse_r : t1_pulse_r;
  assign serial_tx_clock = tx_sel ? t2_baud_pulse_r : t1_pulse_r;

  // ****************************************
  // read data
  // ****************************************
  // sampled in the setup cycle so the word is stable through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= {24'h000000, rd_byte};
    end
  end

endmodule

// ==== test/lmts_pins_model.sv ====
`timescale 1ns/10ps
// ****************************************
// far-side pins: events, gates, trigger
// ****************************************
module lmts_pins_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] gate_lvl,
  input  wire logic       ev_run,
  input  wire logic       trig_go,
  output logic            t0_event_pin,
  output logic            t1_event_pin,
  output logic            t2_event_pin,
  output logic            t2_trigger_pin,
  output logic            ext_irq0_pin,
  output logic            ext_irq1_pin
);
  logic [1:0] div_r;
  logic       ev_r;
  logic [2:0] trig_r;
  // event pins idle high, fall every six clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 2'h0;
      ev_r <= 1'b1;
      trig_r <= 3'h0;
    end else begin
      div_r <= (div_r == 2'h2) ? 2'h0 : div_r + 2'h1;
      ev_r <= ev_run ? (ev_r ^ (div_r == 2'h2)) : 1'b1;
      trig_r <= trig_go ? 3'h4 : trig_r - {2'h0, trig_r != 3'h0};
    end
  end
  assign t0_event_pin = ev_r;
  assign t1_event_pin = ev_r;
  assign t2_event_pin = ev_r;
  assign t2_trigger_pin = (trig_r == 3'h0);
  assign ext_irq0_pin = gate_lvl[0];
  assign ext_irq1_pin = gate_lvl[1];
endmodule

// ==== test/lmts_timer_set_assertions.sv ====
`timescale 1ns/10ps
`include "lmts_params.svh"
module lmts_timer_set_assertions #(
  parameter int ADDR_W = 12
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              t0_vector_ack,
  input wire logic              t0_overflow_pulse,
  input wire logic              t1_overflow_pulse,
  input wire logic              t0_irq_req,
  input wire logic              t2_irq_req,
  input wire logic              serial_tx_clock,
  input wire logic [3:0]        move_cycles
);
  wire  wr_go = psel && penable && pwrite && pstrb[0];
  wire  ck_wr = wr_go && (paddr == {2'b00, `LMTS_IDX_TIMER_RATE_AND_MOVE_STRETCH, 2'b00});
  wire  t2_wr = wr_go && (paddr == {2'b00, `LMTS_IDX_TIMER2_CONTROL, 2'b00});
  wire  aux_wr = wr_go && (paddr == {2'b00, `LMTS_IDX_AUX, 2'b00});
  logic aux_en_r;
  // shadow of the enable, the only way to see it from the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_en_r <= 1'b0;
    end else if (aux_wr) begin
      aux_en_r <= pwdata[0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_ack;
    t0_vector_ack && !wr_go;
  endsequence
  sequence s_force;
    t2_wr && (pwdata[7] || pwdata[6]) && aux_en_r;
  endsequence
  AST_READY: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  AST_SLVERR: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  AST_T0_ONE: assert property (t0_overflow_pulse |=> !t0_overflow_pulse)
    else $error("t0 pulse longer than one cycle");
  AST_T1_ONE: assert property (t1_overflow_pulse |=> !t1_overflow_pulse)
    else $error("t1 pulse longer than one cycle");
  AST_T0_FLAG: assert property (t0_overflow_pulse |-> t0_irq_req)
    else $error("t0 pulse without flag");
  AST_VEC: assert property (s_ack |=> !t0_irq_req || t0_overflow_pulse)
    else $error("vector ack left flag set");
  AST_MOVE: assert property (ck_wr |=> move_cycles == 4'h2 + {1'b0, $past(pwdata[2:0])})
    else $error("move length wrong");
  AST_FORCE: assert property (s_force |=> t2_irq_req)
    else $error("flag write did not raise request");
  AST_TX_ONE: assert property (serial_tx_clock |=> !serial_tx_clock)
    else $error("shift clock longer than one cycle");
endmodule
bind lmts_timer_set lmts_timer_set_assertions #(.ADDR_W(ADDR_W)) u_chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr, .t0_vector_ack,
  .t0_overflow_pulse, .t1_overflow_pulse, .t0_irq_req, .t2_irq_req, .serial_tx_clock,
  .move_cycles);

// ==== test/lmts_timer_set_bench.sv ====
`timescale 1ns/10ps
`include "lmts_params.svh"
module lmts_timer_set_bench import lmts_pkg::*;;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0]  pstrb = 4'hf, move_cycles;
  logic        pready, pslverr, t0_vector_ack = 1'b0, t1_vector_ack = 1'b0;
  logic        t0_event_pin, t1_event_pin, t2_event_pin, t2_trigger_pin;
  logic        ext_irq0_pin, ext_irq1_pin, t0_irq_req, t1_irq_req, t2_irq_req;
  logic        t0_overflow_pulse, t1_overflow_pulse, serial_rx_clock, serial_tx_clock;
  logic        ev_run = 1'b0, trig_go = 1'b0, errv;
  logic [1:0]  gate_lvl = 2'b11;
  logic [7:0]  rdv;
  int          fails = 0, cmp_count = 0;
  always #4 pclk = ~pclk;
  lmts_timer_set u_lmts_timer_set (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .t0_event_pin, .t1_event_pin,
    .t2_event_pin, .t2_trigger_pin, .ext_irq0_pin, .ext_irq1_pin, .t0_vector_ack,
    .t1_vector_ack, .t0_overflow_pulse, .t1_overflow_pulse, .t0_irq_req, .t1_irq_req,
    .t2_irq_req, .serial_rx_clock, .serial_tx_clock, .move_cycles);
  lmts_pins_model u_pins (.pclk, .presetn, .gate_lvl, .ev_run, .trig_go, .t0_event_pin,
    .t1_event_pin, .t2_event_pin, .t2_trigger_pin, .ext_irq0_pin, .ext_irq1_pin);
  // ****************************************
  // shared tasks
  // ****************************************
  task print_verdict();
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // ends on an idle edge so the next call never rewrites psel in one step
  task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata[7:0];
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20) begin
      fails++;
      print_verdict();
    end
  endtask
  task wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task rd(input logic [7:0] idx);
    apb(1'b0, idx, 8'h00);
  endtask
  function logic sig(input int s);
    case (s)
      0: sig = t0_overflow_pulse;
      1: sig = t1_overflow_pulse;
      2: sig = t2_irq_req;
      default: sig = serial_tx_clock;
    endcase
  endfunction
  task wait_on(input int s, output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (sig(s) !== 1'b1 && n < 400);
    if (n >= 400) begin
      fails++;
      print_verdict();
    end
  endtask
  task gap_of(input int s, output int g);
    int n;
    wait_on(s, n);
    wait_on(s, g);
  endtask
  task cnt_on(input int s, output int k);
    k = 0;
    repeat (40) begin
      @(posedge pclk);
      k += (sig(s) === 1'b1);
    end
  endtask
  task trig;
    trig_go <= 1'b1;
    @(posedge pclk);
    trig_go <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_reset;
    rd(`LMTS_IDX_TIMER_RATE_AND_MOVE_STRETCH);
    chk("rate_reset", rdv, 8'h01);
    chk("move_reset", move_cycles, 4'h3);
    wr(`LMTS_IDX_TIMER_RATE_AND_MOVE_STRETCH, 8'h07);
    chk("move_max", move_cycles, 4'h9);
    rd(8'h00);
    chk("unmapped", {errv, rdv}, 9'h100);
  endtask
  task t_mode2;
    int g;
    wr(`LMTS_IDX_T0_HIGH, 8'hff);
    wr(`LMTS_IDX_T0_LOW, 8'hff);
    wr(`LMTS_IDX_TMOD, 8'h02);
    for (int r = 0; r < 2; r++) begin
      wr(`LMTS_IDX_TIMER_RATE_AND_MOVE_STRETCH, r ? 8'h09 : 8'h01);
      wr(`LMTS_IDX_TCON, 8'h10);
      gap_of(0, g);
      chk("t0_gap", g, r ? 4 : 12);
      wr(`LMTS_IDX_TCON, 8'h20);
      rd(`LMTS_IDX_T0_LOW);
      chk("t0_reload", rdv, 8'hff);
    end
    t0_vector_ack <= 1'b1;
    @(posedge pclk);
    t0_vector_ack <= 1'b0;
    @(posedge pclk);
    chk("t0_ack", t0_irq_req, 1'b0);
  endtask
  task t_gate;
    int k;
    gate_lvl <= 2'b10;
    wr(`LMTS_IDX_TMOD, 8'h0a);
    wr(`LMTS_IDX_TCON, 8'h10);
    cnt_on(0, k);
    chk("gated", k, 0);
    gate_lvl <= 2'b11;
    wait_on(0, k);
    wr(`LMTS_IDX_TCON, 8'h00);
  endtask
  task t_wrap;
    int n;
    for (int m = 0; m < 2; m++) begin
      wr(`LMTS_IDX_TIMER_RATE_AND_MOVE_STRETCH, 8'h01);
      wr(`LMTS_IDX_TMOD, m[7:0]);
      wr(`LMTS_IDX_T0_HIGH, 8'hff);
      wr(`LMTS_IDX_T0_LOW, m ? 8'hff : 8'h1f);
      wr(`LMTS_IDX_TCON, 8'h10);
      wait_on(0, n);
      chk("wrap_flag", t0_irq_req, 1'b1);
      wr(`LMTS_IDX_TCON, 8'h00);
      rd(`LMTS_IDX_T0_HIGH);
      chk("wrap_high", rdv, 8'h00);
      rd(`LMTS_IDX_T0_LOW);
      // upper low-byte bits masked in mode 0
      chk("wrap_low", rdv & (m ? 8'hff : 8'h1f), 8'h00);
    end
  endtask
  task t_count;
    int g;
    wr(`LMTS_IDX_TMOD, 8'h06);
    // reload of all ones so every pin fall overflows
    wr(`LMTS_IDX_T0_HIGH, 8'hff);
    wr(`LMTS_IDX_T0_LOW, 8'hff);
    wr(`LMTS_IDX_TIMER_RATE_AND_MOVE_STRETCH, 8'h09);
    ev_run <= 1'b1;
    wr(`LMTS_IDX_TCON, 8'h10);
    gap_of(0, g);
    chk("pin_gap", g, 6);
    ev_run <= 1'b0;
    wr(`LMTS_IDX_TCON, 8'h00);
  endtask
  task t_split;
    int k;
    wr(`LMTS_IDX_T1_HIGH, 8'hff);
    wr(`LMTS_IDX_T1_LOW, 8'hff);
    wr(`LMTS_IDX_TMOD, 8'h23);
    gap_of(1, k);
    chk("rx_from_t1", serial_rx_clock, 1'b1);
    chk("t1_split_gap", k, 12);
    wr(`LMTS_IDX_TMOD, 8'h33);
    cnt_on(1, k);
    chk("t1_stopped", k, 0);
  endtask
  task t_cap;
    wr(`LMTS_IDX_TIMER2_CONTROL, 8'h09);
    wr(`LMTS_IDX_T2_LOW, 8'h34);
    wr(`LMTS_IDX_T2_HIGH, 8'h12);
    trig;
    rd(`LMTS_IDX_RCAP_LOW);
    chk("cap_low", rdv, 8'h34);
    rd(`LMTS_IDX_RCAP_HIGH);
    chk("cap_high", rdv, 8'h12);
    rd(`LMTS_IDX_TIMER2_CONTROL);
    chk("ext_flag", rdv, 8'h49);
    wr(`LMTS_IDX_TIMER2_CONTROL, 8'h01);
    wr(`LMTS_IDX_T2_LOW, 8'h00);
    trig;
    rd(`LMTS_IDX_RCAP_LOW);
    chk("no_cap", rdv, 8'h34);
    rd(`LMTS_IDX_TIMER2_CONTROL);
    chk("no_flag", rdv, 8'h01);
  endtask
  task t_reload;
    int n;
    wr(`LMTS_IDX_AUX, 8'h01);
    wr(`LMTS_IDX_RCAP_LOW, 8'hcd);
    wr(`LMTS_IDX_RCAP_HIGH, 8'hab);
    wr(`LMTS_IDX_T2_LOW, 8'hff);
    wr(`LMTS_IDX_T2_HIGH, 8'hff);
    wr(`LMTS_IDX_TIMER2_CONTROL, 8'h04);
    wait_on(2, n);
    wr(`LMTS_IDX_TIMER2_CONTROL, 8'h00);
    chk("t2_clear", t2_irq_req, 1'b0);
    rd(`LMTS_IDX_T2_HIGH);
    chk("rel_high", rdv, 8'hab);
    rd(`LMTS_IDX_T2_LOW);
    chk("rel_low", rdv, 8'hcd);
    wr(`LMTS_IDX_TIMER2_CONTROL, 8'h80);
    chk("t2_forced", t2_irq_req, 1'b1);
  endtask
  task t_baud;
    int g;
    wr(`LMTS_IDX_TIMER2_CONTROL, 8'h00);
    wr(`LMTS_IDX_RCAP_LOW, 8'hff);
    wr(`LMTS_IDX_RCAP_HIGH, 8'hff);
    // count left from the reload scenario would take far too long to wrap
    wr(`LMTS_IDX_T2_LOW, 8'hff);
    wr(`LMTS_IDX_T2_HIGH, 8'hff);
    wr(`LMTS_IDX_TIMER2_CONTROL, 8'h15);
    gap_of(3, g);
    chk("baud_gap", g, 2);
    chk("baud_flag", t2_irq_req, 1'b0);
    wr(`LMTS_IDX_TIMER2_CONTROL, 8'h00);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_mode2;
    t_gate;
    t_wrap;
    t_count;
    t_split;
    t_cap;
    t_reload;
    t_baud;
    print_verdict();
  end
endmodule
